/* rtl/srbp_pkg.sv */
// package for the sample ring buffer packer: register map, field positions, reset values
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
package srbp_pkg;
  // printed register numbers are not all multiples of four, so each is an index; byte address is index*4
  localparam logic [11:0] IDX_HOST_AVAIL_LENGTH  = 12'h0C8;
  localparam logic [11:0] IDX_HOST_AVAIL_POS     = 12'h0C9;
  localparam logic [11:0] IDX_CARD_RELEASE_LEN   = 12'h0CA;
  localparam logic [11:0] IDX_ADC_FULL_SCALE     = 12'h466;
  localparam logic [11:0] IDX_CTRL               = 12'h010;
  localparam logic [11:0] IDX_STATUS             = 12'h011;
  localparam logic [11:0] IDX_BUF_LEN            = 12'h012;
  localparam logic [11:0] IDX_NOTIFY_SIZE        = 12'h013;
  localparam logic [11:0] IDX_IRQ_STATUS         = 12'h014;
  localparam logic [11:0] IDX_IRQ_ENABLE         = 12'h015;
  localparam logic [11:0] IDX_IRQ_CLEAR          = 12'h016;
  localparam logic [11:0] IDX_FILL_LEVEL         = 12'h017;
  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int CTRL_DIR_BIT   = 2;
  localparam int CTRL_FIRST_BIT  = 3;
  localparam int CTRL_SECOND_BIT = 4;
  localparam int CTRL_DIG_BIT   = 5;
  // interrupt / event bit positions
  localparam int EV_NOTIFY  = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_DONE    = 2;
  localparam int EV_NUM     = 3;
  // reset values and other fixed constants
  localparam logic [31:0] BUF_LEN_RST     = 32'h0000_1000;
  localparam logic [31:0] NOTIFY_SIZE_RST = 32'h0000_0400;
  localparam logic [31:0] ADC_FULL_SCALE  = 32'h0000_2000;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  SAMPLE_BYTES    = 2'h2;
  typedef enum logic [1:0] {
    SRBP_IDLE = 2'b00,
    SRBP_RUN  = 2'b01,
    SRBP_DRAIN = 2'b10
  } srbp_state_t;
endpackage : srbp_pkg

/* rtl/srbp_top.sv */
// sample ring buffer packer: moves 16-bit packed samples between on-board memory and a host ring buffer
// assumes an AHB-Lite slave port, a host memory write/read port with ready, and 14-bit samples on core_clk
// Notes on behaviour
// [R1] - transfer position wraps to byte zero at configured buffer length
// [R2] - host available length counts all available bytes, across the wrap
// [R3] - available position advances past the released region
// [R4] - notify event raised on each crossed notify boundary; amount may exceed a block
// [R5] - host hands back exactly the processed byte count through the release register
// [R6] - streaming runs endlessly while the host releases space in time
// [R7] - for generation the host fills and releases the whole buffer before starting
// [R8] - two channels interleave first then second; one channel writes consecutive samples
// [R9] - sample stored two's complement in low 14 bits of 16-bit word
// [R10] - sample range spans -8192 to +8191
// [R11] - standard mode: bits 15 and 14 repeat converter bit 13
// [R12] - digital mode: bit 15 digital input one, bit 14 digital input zero
// [R13] - read-only full-scale code register reports positive full scale in LSB
// [R14] - consumers mask extra digital bits and sign-extend bit 13
// [R15] - after start, host length is zero and card length is buffer length
// [R16] - on-board fill level reported in sixteenths of memory
// [R17] - overrun or underrun stops transfer and flags error; card-to-host drains first
// [R18] - never touch unreleased ring bytes; stall until space is released
// [R19] - release write lowers host length and advances host position modulo length
`timescale 1ns/1ps
module srbp_top
  import srbp_pkg::*;
#(
  parameter int ADDR_W  = 32,
  parameter int MEM_DEPTH_LOG2 = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // converter samples (same clock domain)
  input  wire logic              sample_valid,
  input  wire logic [13:0]       first_channel,
  input  wire logic [13:0]       second_channel,
  input  wire logic              digital_input_zero,
  input  wire logic              digital_input_one,
  // generation output (host to card)
  output logic                   gen_valid,
  output logic [15:0]            gen_word,
  input  wire logic              gen_ready,
  // host memory port, one 16-bit word per beat
  output logic                   mem_req,
  output logic                   mem_write,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [15:0]            mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rdata,
  output logic                   irq
);
  import srbp_pkg::*;

  localparam int DEPTH = 1 << MEM_DEPTH_LOG2;

  srbp_state_t       state_q;
  logic [31:0]       buf_len_q, notify_q, xfer_pos_q, host_len_q, host_pos_q, card_release_length_q;
  logic [31:0]       since_notify_q;
  logic              dir_q, first_en_q, second_en_q, dig_q;
  logic [EV_NUM-1:0] ev_q, ev_en_q, ev_set;
  logic              err_q;
  // on-board memory
  logic [15:0]       mem_q [DEPTH];
  logic [MEM_DEPTH_LOG2-1:0] wr_ptr_q, rd_ptr_q;
  logic [MEM_DEPTH_LOG2:0]   fill_q;
  // fill level in sixteenths of the on-board memory; a full memory reads 16, so five bits are kept
  logic [4:0]        fill_16th;
  logic [13:0]       hold_b_q;
  logic              hold_v_q;
  // ahb data phase
  logic              dp_valid_q, dp_write_q;
  logic [11:0]       dp_idx_q;
  logic              start_wr, stop_wr, rel_wr, irq_clr_wr;
  logic [31:0]       rel_cnt;

  function automatic logic [15:0] pack(input logic [13:0] s);
    // [R9] [R10] [R11] [R12] low 14 bits keep the two's complement code
    pack = dig_q ? {digital_input_one, digital_input_zero, s} : {s[13], s[13], s};
  endfunction : pack

  // ahb-lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_idx_q   <= 12'h000;
    end else if (hready) begin
      dp_valid_q <= hsel && htrans == HTRANS_NONSEQ;
      dp_write_q <= hwrite;
      dp_idx_q   <= haddr[13:2];
    end
  end

  // only address bits 13:2 are decoded, so the register map repeats every 16 KB
  assign start_wr = dp_valid_q && dp_write_q && dp_idx_q == IDX_CTRL && hwdata[CTRL_START_BIT];
  assign stop_wr  = dp_valid_q && dp_write_q && dp_idx_q == IDX_CTRL && hwdata[CTRL_STOP_BIT];
  assign rel_wr   = dp_valid_q && dp_write_q && dp_idx_q == IDX_CARD_RELEASE_LEN;
  assign irq_clr_wr = dp_valid_q && dp_write_q && dp_idx_q == IDX_IRQ_CLEAR;
  // [R5] the host is trusted not to release more than it holds; clip keeps counters sane if it does
  assign rel_cnt  = (hwdata > host_len_q) ? host_len_q : hwdata;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_valid_q && !dp_write_q) begin
      unique case (dp_idx_q)
        IDX_HOST_AVAIL_LENGTH: hrdata = host_len_q;           // [R2]
        IDX_HOST_AVAIL_POS:    hrdata = host_pos_q;           // [R3]
        IDX_ADC_FULL_SCALE:    hrdata = ADC_FULL_SCALE;       // [R13]
        IDX_CTRL:              hrdata = {26'h0, dig_q, second_en_q, first_en_q, dir_q, 2'h0};
        IDX_STATUS:            hrdata = {29'h0, err_q, state_q};
        IDX_BUF_LEN:           hrdata = buf_len_q;
        IDX_NOTIFY_SIZE:       hrdata = notify_q;
        IDX_IRQ_STATUS:        hrdata = {29'h0, ev_q};
        IDX_IRQ_ENABLE:        hrdata = {29'h0, ev_en_q};
        IDX_FILL_LEVEL:        hrdata = {27'h0, fill_16th};   // [R16]
        default:               hrdata = 32'h0000_0000;
      endcase
    end
  end

  // configuration, writable only while idle; interrupt enables writable at any time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_len_q <= BUF_LEN_RST;
      notify_q  <= NOTIFY_SIZE_RST;
      dir_q     <= 1'b0;
      first_en_q  <= 1'b1;
      second_en_q <= 1'b0;
      dig_q     <= 1'b0;
      ev_en_q   <= '0;
    end else if (dp_valid_q && dp_write_q) begin
      if (dp_idx_q == IDX_IRQ_ENABLE) ev_en_q <= hwdata[EV_NUM-1:0];
      if (state_q == SRBP_IDLE) begin
        if (dp_idx_q == IDX_BUF_LEN)     buf_len_q <= hwdata;
        if (dp_idx_q == IDX_NOTIFY_SIZE) notify_q  <= hwdata;
        if (dp_idx_q == IDX_CTRL) begin
          dir_q <= hwdata[CTRL_DIR_BIT];
          first_en_q  <= hwdata[CTRL_FIRST_BIT];
          second_en_q <= hwdata[CTRL_SECOND_BIT];
          dig_q <= hwdata[CTRL_DIG_BIT];
        end
      end
    end
  end

  // on-board fifo: acquisition fills, host writes drain; generation is the reverse
  logic push, pop, ovf, beat;
  logic [15:0] push_data;
  logic        ring_ok;
  assign ring_ok = card_release_length_q >= 32'(SAMPLE_BYTES);                  // [R18]
  assign beat    = mem_req && mem_ack;
  // direction only changes while idle, so mem_write never moves under a held request
  assign mem_write = !dir_q;
  assign mem_addr  = ADDR_W'(xfer_pos_q);
  assign mem_wdata = mem_q[rd_ptr_q];
  assign mem_req   = (state_q != SRBP_IDLE) && ring_ok &&            // [R18] stall until released
                     (dir_q ? (fill_q < (MEM_DEPTH_LOG2+1)'(DEPTH)) && state_q == SRBP_RUN
                            : fill_q != '0);
  assign gen_valid = dir_q && state_q == SRBP_RUN && fill_q != '0;
  assign gen_word  = mem_q[rd_ptr_q];
  assign fill_16th = fill_q[MEM_DEPTH_LOG2 -: 5];                     // [R16]

  // [R8] acquisition push: with both channels a second beat carries the held second sample
  logic acq_in;
  assign acq_in = !dir_q && state_q == SRBP_RUN && (first_en_q || second_en_q);
  always_comb begin
    push      = 1'b0;
    push_data = pack(first_en_q ? first_channel : second_channel);
    if (dir_q) begin
      push      = beat;
      push_data = mem_rdata;
    end else if (hold_v_q) begin
      push      = acq_in;
      push_data = pack(hold_b_q);
    end else if (sample_valid) begin
      push      = acq_in;
    end
  end
  assign pop = dir_q ? (gen_valid && gen_ready) : beat;
  // generation: gen_ready raised before the first words arrive already counts as an underrun
  // [R17] overrun: a sample arrives with the memory full; underrun: generator starved
  assign ovf = dir_q ? (gen_ready && fill_q == '0 && state_q == SRBP_RUN)
                     : (push && fill_q == (MEM_DEPTH_LOG2+1)'(DEPTH) && !pop);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_v_q <= 1'b0;
      hold_b_q <= 14'h0000;
    // a sample_valid while the second word is still held is lost; sources leave one idle cycle
    end else if (acq_in && !hold_v_q && sample_valid && first_en_q && second_en_q) begin
      hold_v_q <= 1'b1;                                             // [R8]
      hold_b_q <= second_channel;
    end else if (acq_in) begin
      hold_v_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && !ovf) mem_q[wr_ptr_q] <= push_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
    end else if (start_wr && state_q == SRBP_IDLE) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
    end else begin
      if (push && !ovf) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      fill_q <= fill_q + (MEM_DEPTH_LOG2+1)'(push && !ovf) - (MEM_DEPTH_LOG2+1)'(pop);
    end
  end

  // transfer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= SRBP_IDLE;
      err_q   <= 1'b0;
    end else begin
      unique case (state_q)
        SRBP_IDLE: if (start_wr) begin
          state_q <= SRBP_RUN;
          err_q   <= 1'b0;
        end
        SRBP_RUN: if (ovf) begin
          err_q   <= 1'b1;                                           // [R17]
          state_q <= dir_q ? SRBP_IDLE : SRBP_DRAIN;                 // [R17] acquisition drains first
        end else if (stop_wr) begin
          state_q <= dir_q ? SRBP_IDLE : SRBP_DRAIN;
        end
        SRBP_DRAIN: if (fill_q == '0 || stop_wr) state_q <= SRBP_IDLE;
        default: state_q <= SRBP_IDLE;
      endcase
    end
  end

  // ring counters
  logic [31:0] pos_next, hpos_sum;
  assign pos_next = xfer_pos_q + 32'(SAMPLE_BYTES);
  assign hpos_sum = host_pos_q + rel_cnt;
  logic notify_hit;
  assign notify_hit = beat && (since_notify_q + 32'(SAMPLE_BYTES) >= notify_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_pos_q     <= 32'h0000_0000;
      host_len_q     <= 32'h0000_0000;
      host_pos_q     <= 32'h0000_0000;
      card_release_length_q     <= 32'h0000_0000;
      since_notify_q <= 32'h0000_0000;
    // a start while running is ignored, so the ring counters never jump mid-transfer
    end else if (start_wr && state_q == SRBP_IDLE) begin
      xfer_pos_q     <= 32'h0000_0000;
      host_len_q     <= 32'h0000_0000;                              // [R15]
      host_pos_q     <= 32'h0000_0000;
      card_release_length_q     <= buf_len_q;                                  // [R15] [R7]
      since_notify_q <= 32'h0000_0000;
    end else begin
      if (beat) xfer_pos_q <= (pos_next >= buf_len_q) ? 32'h0000_0000 : pos_next; // [R1]
      // [R4] bytes reach the host in notify-size steps; each step is announced on the beat that completes it
      if (notify_hit) since_notify_q <= 32'h0000_0000;
      else if (beat) since_notify_q <= since_notify_q + 32'(SAMPLE_BYTES);
      host_len_q <= host_len_q - (rel_wr ? rel_cnt : 32'h0)
                    + (notify_hit ? since_notify_q + 32'(SAMPLE_BYTES) : 32'h0); // [R2] [R4] [R19]
      card_release_length_q <= card_release_length_q + (rel_wr ? rel_cnt : 32'h0)
                    - (beat ? 32'(SAMPLE_BYTES) : 32'h0);            // [R6] [R18]
      if (rel_wr) host_pos_q <= (hpos_sum >= buf_len_q) ? hpos_sum - buf_len_q : hpos_sum; // [R3] [R19]
    end
  end

  // interrupts: set wins over a same-cycle clear
  assign ev_set = {state_q == SRBP_DRAIN && fill_q == '0 || (state_q == SRBP_RUN && stop_wr && dir_q),
                   state_q == SRBP_RUN && ovf,
                   notify_hit};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~(irq_clr_wr ? hwdata[EV_NUM-1:0] : '0))
              | ev_set;
    end
  end
  assign irq = |(ev_q & ev_en_q);
endmodule : srbp_top

/* tb/srbp_chk.sv */
// checker for the sample ring buffer packer: bus answer and host memory beat rules
// assumes it sees only srbp_top ports; bound at the foot of this file
`timescale 1ns/1ps
module srbp_chk #(
  parameter int ADDR_W = 32
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              mem_req,
  input wire logic              mem_write,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [15:0]       mem_wdata,
  input wire logic              mem_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [ADDR_W-1:0] last_q;
  logic              seen_q;
  // remembers the previous beat so the next one must step by one word or wrap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_q <= '0;
      seen_q <= 1'b0;
    end else if (mem_req && mem_ack) begin
      last_q <= mem_addr;
      seen_q <= 1'b1;
    end
  end
  ready_zero_wait_a: assert property (hreadyout == 1'b1) else $error("slave inserted a wait state");
  resp_always_okay_a: assert property (hresp == 1'b0) else $error("slave answered with an error response");
  req_held_a: assert property (mem_req && !mem_ack |=> mem_req) else $error("memory request dropped early");
  addr_held_a: assert property (mem_req && !mem_ack |=> $stable(mem_addr)) else $error("address moved");
  data_held_a: assert property (mem_req && !mem_ack |=> $stable(mem_wdata)) else $error("write data moved");
  dir_held_a: assert property (mem_req && !mem_ack |=> $stable(mem_write)) else $error("direction moved");
  word_aligned_a: assert property (mem_req |-> mem_addr[0] == 1'b0) else $error("beat not word aligned");
  ring_step_a: assert property (mem_req && mem_ack && seen_q |-> mem_addr == last_q + 2 || mem_addr == '0)
    else $error("ring position skipped");
endmodule : srbp_chk
bind srbp_top srbp_chk #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack));

/* tb/srbp_host_mem.sv */
// host ring memory model: acknowledges beats after a random delay, stores writes
// assumes mem_req is held until acknowledged; read data is only valid in the ack cycle
`timescale 1ns/1ps
module srbp_host_mem #(
  parameter int ADDR_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              mem_req,
  input  wire logic              mem_write,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [15:0]       mem_wdata,
  output logic                   mem_ack,
  output logic [15:0]            mem_rdata
);
  logic [15:0] mem_q [0:255];
  logic [15:0] last_q;
  // never acks without a request, and acks are one cycle wide
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      last_q  <= 16'h0000;
    end else begin
      mem_ack <= mem_req && !mem_ack && ($urandom_range(2) == 0);
      if (mem_req && mem_ack && mem_write) mem_q[mem_addr[8:1]] <= mem_wdata;
      if (mem_req && mem_ack && !mem_write) last_q <= mem_q[mem_addr[8:1]];
    end
  end
  // outside an ack the read bus shows the inverted last read word, not the stale word
  assign mem_rdata = (mem_req && mem_ack && !mem_write) ? mem_q[mem_addr[8:1]] : ~last_q;
endmodule : srbp_host_mem

/* tb/tb.sv */
// testbench for srbp_top: register map, ring wrap, release counting, stall, packing, interrupt
// assumes a zero-wait AHB-Lite slave and the host memory model on the far side
`timescale 1ns/1ps
module tb;
  import srbp_pkg::*;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, sample_valid = 0, rd_dp = 0, hold_exp = 0;
  logic digital_input_zero = 0, digital_input_one = 0, gen_ready = 0;
  logic [31:0] haddr = 0, hwdata = 0, blen = 32'h0000_0040;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [13:0] first_channel = 0, second_channel = 0;
  wire logic hreadyout, hresp, gen_valid, mem_req, mem_write, mem_ack, irq;
  wire logic [31:0] hrdata, mem_addr;
  wire logic [15:0] gen_word, mem_wdata, mem_rdata;
  int n_fail = 0, num_checks = 0, cyc = 0, wcnt = 0, rcnt = 0;
  logic [31:0] rq[$], aq[$];
  logic [15:0] wq[$], pq[$], gq[$];
  // expected content of the host ring, word by word, as the bench wrote it
  logic [15:0] hm [0:31];
  initial forever #50 core_clk = ~core_clk;
  srbp_top dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sample_valid(sample_valid), .first_channel(first_channel), .second_channel(second_channel),
    .digital_input_zero(digital_input_zero), .digital_input_one(digital_input_one), .gen_valid(gen_valid),
    .gen_word(gen_word), .gen_ready(gen_ready), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
  srbp_host_mem host (.core_clk(core_clk), .rst(rst), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_w(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  // one single transfer; read expectations go to the queue for the watcher
  task automatic ahb(logic [11:0] i, logic w, logic [31:0] d, logic [31:0] e);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {18'h0, i, 2'b00};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) rq.push_back(e);
    if (!w) rd_dp <= 1'b1;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd_dp <= 1'b0;
  endtask : ahb
  task automatic send(logic [13:0] a, logic [13:0] b, logic two, logic dig);
    logic d0, d1;
    d0 = 1'($urandom);
    d1 = 1'($urandom);
    sample_valid <= 1'b1;
    first_channel <= a;
    second_channel <= b;
    digital_input_zero <= d0;
    digital_input_one <= d1;
    pq.push_back(dig ? {d1, d0, a} : {a[13], a[13], a});
    if (two) pq.push_back(dig ? {d1, d0, b} : {b[13], b[13], b});
    if (!hold_exp) flush();
    @(posedge core_clk);
    sample_valid <= 1'b0;
    @(posedge core_clk);
  endtask : send
  task automatic burst(int n, logic two, logic dig);
    repeat (n) send(14'($urandom), 14'($urandom), two, dig);
  endtask : burst
  // words become expected only here, so any beat before release is caught as unexpected
  task automatic flush();
    while (pq.size() > 0) begin
      wq.push_back(pq.pop_front());
      aq.push_back((wcnt * 2) % blen);
      wcnt++;
    end
  endtask : flush
  task automatic settle();
    int k;
    k = 0;
    while (wq.size() > 0 && k < 800) begin
      @(posedge core_clk);
      k++;
    end
    repeat (4) @(posedge core_clk);
  endtask : settle
  task automatic chk_irq(logic e);
    @(posedge core_clk);
    chk_reg("irq", {31'h0, e}, {31'h0, irq});
  endtask : chk_irq
  always @(posedge core_clk) begin
    if (rd_dp && hreadyout === 1'b1) chk_reg("hrdata", rq.pop_front(), hrdata);
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_write === 1'b1) begin
      if (wq.size() == 0) begin
        n_fail++;
        $display("wrong value mem_beat expected none seen %h", mem_addr);
      end else begin
        hm[aq[0][5:1]] = wq[0];
        chk_reg("mem_addr", aq.pop_front(), mem_addr);
        chk_w("sample_field", {{2{wq[0][13]}}, wq[0][13:0]}, {{2{mem_wdata[13]}}, mem_wdata[13:0]});
        chk_w("mem_wdata", wq.pop_front(), mem_wdata);
      end
    end else if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      chk_reg("mem_raddr", (rcnt * 2) % blen, mem_addr);
      rcnt++;
    end
    if (gen_valid === 1'b1 && gen_ready === 1'b1) begin
      if (gq.size() == 0) begin
        n_fail++;
        $display("wrong value gen_beat expected none seen %h", gen_word);
      end else begin
        chk_w("gen_word", gq.pop_front(), gen_word);
      end
    end
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      $display("wrong value timeout expected done seen hang");
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h1c86e14d));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    ahb(IDX_BUF_LEN, 0, 0, BUF_LEN_RST);
    ahb(IDX_NOTIFY_SIZE, 0, 0, NOTIFY_SIZE_RST);
    ahb(IDX_ADC_FULL_SCALE, 1, 32'h0000_1234, 0);
    ahb(IDX_ADC_FULL_SCALE, 0, 0, ADC_FULL_SCALE);
    ahb(IDX_FILL_LEVEL, 0, 0, 0);
    ahb(IDX_IRQ_STATUS, 0, 0, 0);
    ahb(12'h3FF, 0, 0, 0);
    $display("test reset_map done");
    ahb(IDX_BUF_LEN, 1, blen, 0);
    ahb(IDX_NOTIFY_SIZE, 1, 32'h0000_0010, 0);
    ahb(IDX_CTRL, 1, 32'h0000_0019, 0);
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 0);
    send(14'h2000, 14'h1FFF, 1, 0);
    burst(7, 1, 0);
    flush();
    settle();
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0020);
    ahb(IDX_HOST_AVAIL_POS, 0, 0, 0);
    ahb(IDX_IRQ_ENABLE, 1, 32'h0000_0001, 0);
    chk_irq(1'b1);
    ahb(IDX_IRQ_ENABLE, 1, 0, 0);
    chk_irq(1'b0);
    ahb(IDX_IRQ_ENABLE, 1, 32'h0000_0001, 0);
    ahb(IDX_IRQ_CLEAR, 1, 32'h0000_0001, 0);
    chk_irq(1'b0);
    $display("test first_block done");
    ahb(IDX_CARD_RELEASE_LEN, 1, 32'h0000_0010, 0);
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0010);
    ahb(IDX_HOST_AVAIL_POS, 0, 0, 32'h0000_0010);
    burst(12, 1, 0);
    flush();
    settle();
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0040);
    hold_exp = 1;
    burst(4, 1, 0);
    repeat (60) @(posedge core_clk);
    ahb(IDX_CARD_RELEASE_LEN, 1, 32'h0000_0040, 0);
    flush();
    hold_exp = 0;
    settle();
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0010);
    ahb(IDX_HOST_AVAIL_POS, 0, 0, 32'h0000_0010);
    $display("test wrap_stall done");
    ahb(IDX_CTRL, 1, 32'h0000_0002, 0);
    repeat (40) @(posedge core_clk);
    ahb(IDX_CTRL, 1, 32'h0000_0029, 0);
    wcnt = 0;
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 0);
    burst(8, 0, 1);
    flush();
    settle();
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0010);
    $display("test digital_single done");
    ahb(IDX_CTRL, 1, 32'h0000_0002, 0);
    repeat (40) @(posedge core_clk);
    ahb(IDX_CTRL, 1, 32'h0000_000D, 0);
    repeat (400) @(posedge core_clk);
    ahb(IDX_FILL_LEVEL, 0, 0, 32'h0000_0002); // 32 of 256 words is two sixteenths
    ahb(IDX_HOST_AVAIL_LENGTH, 0, 0, 32'h0000_0040);
    for (int i = 0; i < 16; i++) gq.push_back(hm[i]);
    gen_ready <= 1'b1;
    repeat (16) @(posedge core_clk);
    gen_ready <= 1'b0;
    ahb(IDX_CTRL, 1, 32'h0000_0002, 0);
    chk_reg("gen_left", 32'h0000_0000, gq.size());
    chk_reg("mem_reads", 32'h0000_0020, rcnt);
    $display("test generation done");
    finish_test();
  end
endmodule : tb
